// >>> shared/smg_pkg.sv
package smg_pkg;

  // Register byte addresses
  localparam logic [31:0] SLEEP_CTRL_ADDR = 32'h0000_0000;
  localparam logic [31:0] CORE_CTRL_ADDR  = 32'h0000_0004;
  localparam logic [31:0] STOP_MASK_ADDR  = 32'h0000_0008;
  localparam logic [31:0] STATUS_ADDR     = 32'h0000_000C;

  // Field positions
  localparam int ALLOW_BIT   = 0;
  localparam int SEL_LSB     = 1;
  localparam int UNLOCK_BIT  = 5;
  localparam int OFF_BIT     = 6;
  localparam int PERIPH_N    = 6;

  // Reset values
  localparam logic [1:0] SEL_RST   = 2'h0;
  localparam logic [5:0] STOP_RST  = 6'h00;

  // Timed sequence counts
  localparam logic [2:0] UNLOCK_CYC = 3'h4;
  localparam logic [1:0] ARM_CYC    = 2'h3;
  localparam logic [1:0] HOLD_CYC   = 2'h3;
  localparam logic [13:0] HALT_CYC  = 14'h0004;

  // Wake timing
  localparam int CLK_NS        = 5;
  localparam int BOD_WAKE_US   = 60;
  localparam int BOD_WAKE_CYC  = (BOD_WAKE_US * 1000 + CLK_NS - 1) / CLK_NS;
  localparam logic [13:0] STARTUP_UNIT = 14'h0040;

  // Bus answers
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    SMG_IDLE,
    SMG_NOISE,
    SMG_PDOWN,
    SMG_PSAVE
  } smg_mode_e;

  typedef enum logic [1:0] {
    ST_RUN,
    ST_SLEEP,
    ST_WAKE,
    ST_HALT
  } smg_state_e;

endpackage

// >>> verification/smg_sleep_ctrl_tb.sv
`timescale 1ns/100ps
module smg_sleep_ctrl_tb;
  // Short monitor-off stretch so the deep wake is still longer than the fuse delay
  localparam logic [13:0] MON_WAKE = 14'h00C8;

  logic        clock = 1'b0;
  logic        sys_rst = 1'b1;
  logic [31:0] awaddr = 32'h0000_0000;
  logic [31:0] wdata = 32'h0000_0000;
  logic [31:0] araddr = 32'h0000_0000;
  logic [31:0] rdata;
  logic [3:0]  wstrb = 4'hF;
  logic        awvalid = 1'b0;
  logic        wvalid = 1'b0;
  logic        bready = 1'b0;
  logic        arvalid = 1'b0;
  logic        rready = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [1:0]  bresp, rresp;
  logic        sleepInstr = 1'b0;
  logic        clkEn = 1'b1;
  logic        t0Async = 1'b0;
  logic        cmpRef = 1'b0;
  logic        monFuse = 1'b1;
  logic        adcEnabled = 1'b1;
  logic        comparatorOff = 1'b1;
  logic [3:0]  clockSelectFuse = 4'h0;
  logic [10:0] wake = 11'h000;
  logic        cpuClkEn, flashClkEn, ioClkEn, adcClkEn, asyncClockEn, mainOscEn, coreHalt;
  logic        monOn, forceOff, vrefOn, adcAutoStart, adcExtendedNext, timer0Undefined;
  logic [5:0]  periphClkEn, periphAccessEn;
  logic [5:0]  mask = 6'h00;
  logic [31:0] seed = 32'h5E42;
  logic [31:0] rd;
  logic [1:0]  resp;
  int          num_errors = 0;
  int          comparisons = 0;

  // Wake inputs packed as one vector so a table can pick among them
  smg_sleep_ctrl #(.BOD_WAKE_CYCLES(MON_WAKE)) i_smg_sleep_ctrl (
    .clock(clock), .sys_rst(sys_rst), .clkEn(clkEn),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
    .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
    .rvalid(rvalid), .rready(rready), .sleepInstr(sleepInstr),
    .clockSelectFuse(clockSelectFuse), .brownoutThresholdFuse(monFuse),
    .irqAny(wake[10]), .adcDone(wake[9]), .extLevelIrq(wake[8]), .pinChange(wake[7]),
    .wdtIrq(wake[6]), .usiStart(wake[5]), .asyncTimerIrq(wake[4]), .spmReady(wake[3]),
    .resetWake(wake[2]), .timer0Ovf(wake[1]), .timer0Cmp(wake[0]),
    .timer0IrqMask(2'h3), .globalIrqEn(1'b1), .timer0AsyncSelect(t0Async),
    .adcEnabled(adcEnabled), .comparatorOff(comparatorOff), .comparatorUsesRef(cmpRef),
    .cpuClkEn(cpuClkEn), .flashClkEn(flashClkEn), .ioClkEn(ioClkEn), .adcClkEn(adcClkEn),
    .asyncClockEn(asyncClockEn), .mainOscEn(mainOscEn), .periphClkEn(periphClkEn),
    .periphAccessEn(periphAccessEn), .coreHalt(coreHalt), .brownoutMonitorOn(monOn),
    .comparatorForceOff(forceOff), .vrefOn(vrefOn), .adcAutoStart(adcAutoStart),
    .adcExtendedNext(adcExtendedNext), .timer0Undefined(timer0Undefined)
  );

  // 200 MHz system clock
  always #2.5 clock = ~clock;

  // Repeatable random source
  function automatic logic [31:0] lfsrNext(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  // Random wake source allowed in the given mode; falls back to reset wake
  function automatic logic [10:0] pickWake(input int m);
    logic [10:0] legal;
    int          b;
    legal = (m == 0) ? 11'h404 : (m == 1) ? 11'h3FC : (m == 2) ? 11'h1E4 : 11'h1E7;
    for (int k = 0; k < 64; k++) begin
      seed = lfsrNext(seed);
      b = int'(seed % 32'd11);
      if (legal[b]) begin
        return 11'h001 << b;
      end
    end
    return 11'h004;
  endfunction

  // Sources that must not wake the given mode
  function automatic logic [10:0] wrongMask(input int m);
    return (m == 0) ? 11'h000 : (m == 1) ? 11'h400 : (m == 2) ? 11'h61B : 11'h608;
  endfunction

  // Edges from wake sample until halt is seen low: wait, four halt cycles, one sample lag
  function automatic logic [31:0] expHalt(input int m, input logic [3:0] f, input logic off);
    int load;
    load = (m < 2) ? 1 : (int'(f) + 1) * 64;
    if (off && load < int'(MON_WAKE)) begin
      load = int'(MON_WAKE);
    end
    return 32'(load + 6);
  endfunction

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic conclude;
    $display("counts: %0d comparisons, %0d mismatches", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // A wait that ran out counts as a mismatch and ends the run
  task automatic stuck;
    num_errors++;
    $display("wait limit reached at %0t", $time);
    conclude;
  endtask

  // Bus write: both halves offered together, each dropped when taken
  task automatic busWrite(input logic [31:0] a, input logic [31:0] d);
    int n;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (n = 0; n < 100; n++) begin
      @(posedge clock);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid && bready) break;
    end
    if (n == 100) stuck;
    resp = bresp;
    bready <= 1'b0;
    // One idle edge so the next call never reassigns bready in this step
    @(posedge clock);
  endtask

  task automatic busRead(input logic [31:0] a);
    int n;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (n = 0; n < 100; n++) begin
      @(posedge clock);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid && rready) break;
    end
    if (n == 100) stuck;
    rd = rdata;
    resp = rresp;
    rready <= 1'b0;
    @(posedge clock);
  endtask

  // Sleep entry, gating check, wrong sources ignored, then a legal wake timed
  task automatic sleepWake(input int m, input logic monOff);
    int n;
    sleepInstr <= 1'b1;
    @(posedge clock);
    sleepInstr <= 1'b0;
    @(posedge clock);
    check(cpuClkEn, 32'h0);
    check(flashClkEn, 32'h0);
    check(ioClkEn, 32'(m == 0));
    check(periphClkEn, (m == 0) ? {26'h0, ~mask} : 32'h0);
    check(adcClkEn, 32'(m < 2));
    check(mainOscEn, 32'(m < 2));
    check(asyncClockEn, 32'(m != 2));
    check(adcAutoStart, 32'(m < 2));
    check(forceOff, 32'(m > 1 && !cmpRef));
    check(monOn, 32'(!monOff));
    wake <= wrongMask(m);
    repeat (8) @(posedge clock);
    check(coreHalt, 32'h1);
    wake <= pickWake(m);
    for (n = 1; n < 2000; n++) begin
      @(posedge clock);
      wake <= 11'h000;
      if (coreHalt === 1'b0) break;
    end
    if (n == 2000) stuck;
    check(32'(n), expHalt(m, clockSelectFuse, monOff));
    check(monOn, 32'h1);
  endtask

  // Main sequence; a reason for small delays: whole run stays a few thousand cycles
  initial begin
    repeat (16) @(posedge clock);
    sys_rst <= 1'b0;
    @(posedge clock);
    check({cpuClkEn, coreHalt, periphClkEn, monOn}, 32'h17F);
    for (int a = 0; a < 16; a += 4) begin
      busRead(32'(a));
      check(rd, 32'h0);
      check(resp, smg_pkg::RESP_OKAY);
    end
    busRead(32'h0000_0010);
    check(resp, smg_pkg::RESP_SLVERR);
    busWrite(32'h0000_0040, 32'h0000_00FF);
    check(resp, smg_pkg::RESP_SLVERR);
    $display("test reset and map done");
    // Random clock-stop masks
    repeat (3) begin
      seed = lfsrNext(seed);
      mask = seed[5:0];
      busWrite(smg_pkg::STOP_MASK_ADDR, {26'h0, mask});
      check(periphAccessEn, {26'h0, ~mask});
      check(periphClkEn, {26'h0, ~mask});
    end
    $display("test clock stop done");
    // Sleep request with allow clear
    busWrite(smg_pkg::SLEEP_CTRL_ADDR, 32'h0000_0006);
    sleepInstr <= 1'b1;
    @(posedge clock);
    sleepInstr <= 1'b0;
    repeat (2) @(posedge clock);
    check({coreHalt, cpuClkEn}, 32'h1);
    $display("test no allow done");
    // Every mode twice, random fuse and wake source
    for (int i = 0; i < 8; i++) begin
      seed = lfsrNext(seed);
      clockSelectFuse <= {2'b00, seed[1:0]};
      cmpRef <= seed[2];
      t0Async <= (i == 7);
      busWrite(smg_pkg::SLEEP_CTRL_ADDR, 32'((i % 4) * 2 + 1));
      sleepWake(i % 4, 1'b0);
      check(timer0Undefined, 32'(i == 3));
    end
    $display("test modes done");
    // Monitor-off without unlock, sleep after the off stretch has expired, then in time
    clockSelectFuse <= 4'h0;
    cmpRef <= 1'b0;
    busWrite(smg_pkg::SLEEP_CTRL_ADDR, 32'h0000_0005);
    busWrite(smg_pkg::CORE_CTRL_ADDR, 32'h0000_0040);
    sleepWake(2, 1'b0);
    busWrite(smg_pkg::CORE_CTRL_ADDR, 32'h0000_0060);
    busWrite(smg_pkg::CORE_CTRL_ADDR, 32'h0000_0040);
    repeat (10) @(posedge clock);
    sleepWake(2, 1'b0);
    busWrite(smg_pkg::CORE_CTRL_ADDR, 32'h0000_0060);
    busWrite(smg_pkg::CORE_CTRL_ADDR, 32'h0000_0040);
    repeat (2) @(posedge clock);
    sleepWake(2, 1'b1);
    busRead(smg_pkg::CORE_CTRL_ADDR);
    check(rd[6], 32'h0);
    $display("test monitor off done");
    // Converter off and on, reference demand
    adcEnabled <= 1'b0;
    comparatorOff <= 1'b0;
    repeat (3) @(posedge clock);
    check({adcExtendedNext, vrefOn}, 32'h3);
    monFuse <= 1'b0;
    repeat (2) @(posedge clock);
    check({monOn, vrefOn}, 32'h0);
    cmpRef <= 1'b1;
    @(posedge clock);
    check(vrefOn, 32'h1);
    adcEnabled <= 1'b1;
    wake <= 11'h200;
    @(posedge clock);
    wake <= 11'h000;
    repeat (2) @(posedge clock);
    check({adcExtendedNext, vrefOn}, 32'h1);
    $display("test analog done");
    // Frozen block must ignore a sleep request and refuse the bus
    clkEn <= 1'b0;
    sleepInstr <= 1'b1;
    @(posedge clock);
    sleepInstr <= 1'b0;
    @(posedge clock);
    check({coreHalt, awready}, 32'h0);
    clkEn <= 1'b1;
    repeat (2) @(posedge clock);
    check({coreHalt, awready}, 32'h1);
    $display("test freeze done");
    conclude;
  end
endmodule

// >>> verilog/smg_sleep_ctrl.sv
// The AXI4-Lite slave port and the address map are this design's own decisions.
`timescale 1ns/100ps
// Summary of operation
// - Brown-out monitor is off during sleep when disabled, back on at every wake.
// - Wake after monitor-off sleep is stretched to about 60 us.
// - Sleep-off bit resets to zero; acts only in modes allowing software disable.
// - Sleep-off bit changes only through an unlock-gated timed sequence.
// - Set off and unlock, then off alone within four cycles, else ignored.
// - Sleep-off goes active three cycles after set, clears after three more.
// - Sleep entered only with sleep-allow set; mode from sleep-select bits.
// - Core held four extra cycles after start-up before resuming.
// - Select 00 is idle: only CPU and flash clocks stop.
// - Idle wakes on any enabled interrupt.
// - Enabled converter starts a conversion on idle or noise-mode entry.
// - Select 01 is noise mode: I/O, CPU and flash clocks stop.
// - Noise mode wakes on the power-down sources plus converter done, async timer and SPM ready.
// - Select 10 is power-down: all generated clocks and oscillator stop.
// - Power-down wakes only on resets, watchdog, serial start, level, pin change.
// - Power-down exit waits a start-up delay set by the clock-select fuse.
// - Select 11 is power-save: power-down with the async clock kept.
// - Power-save also wakes on unmasked timer 0 events with global enable.
// - Timer 0 contents flagged undefined after power-save without async mode.
// - Clock-stop bit freezes a peripheral and blocks its register access.
// - Clearing a clock-stop bit resumes the peripheral unchanged.
// - Clock stopping acts in active and idle; deeper modes stop anyway.
// - Converter stays enabled in sleep; re-enable forces an extended conversion.
// - Comparator forced off in power-down and save unless using the reference.
// - Reference powered while monitor, comparator or converter needs it.
module smg_sleep_ctrl #(
  parameter logic [13:0] BOD_WAKE_CYCLES = 14'(smg_pkg::BOD_WAKE_CYC)
) (
  input  wire logic        clock,
  input  wire logic        sys_rst,
  input  wire logic        clkEn,
  // AXI4-Lite slave
  input  wire logic [31:0] awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  input  wire logic [31:0] araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  // Core and fuses
  input  wire logic        sleepInstr,
  input  wire logic [3:0]  clockSelectFuse,
  input  wire logic        brownoutThresholdFuse,
  // Wake sources
  input  wire logic        irqAny,
  input  wire logic        resetWake,
  input  wire logic        adcDone,
  input  wire logic        extLevelIrq,
  input  wire logic        pinChange,
  input  wire logic        wdtIrq,
  input  wire logic        usiStart,
  input  wire logic        asyncTimerIrq,
  input  wire logic        spmReady,
  input  wire logic        timer0Ovf,
  input  wire logic        timer0Cmp,
  input  wire logic [1:0]  timer0IrqMask,
  input  wire logic        globalIrqEn,
  input  wire logic        timer0AsyncSelect,
  // Analog status
  input  wire logic        adcEnabled,
  input  wire logic        comparatorOff,
  input  wire logic        comparatorUsesRef,
  // Clock and power controls
  output logic             cpuClkEn,
  output logic             flashClkEn,
  output logic             ioClkEn,
  output logic             adcClkEn,
  output logic             asyncClockEn,
  output logic             mainOscEn,
  output logic [5:0]       periphClkEn,
  output logic [5:0]       periphAccessEn,
  output logic             coreHalt,
  output logic             brownoutMonitorOn,
  output logic             comparatorForceOff,
  output logic             vrefOn,
  output logic             adcAutoStart,
  output logic             adcExtendedNext,
  output logic             timer0Undefined
);

  typedef struct packed {
    smg_pkg::smg_state_e st;
    smg_pkg::smg_mode_e  mode;
    logic [1:0]          sleepSelect;
    logic                sleepAllow;
    logic [2:0]          unlockCnt;
    logic [1:0]          armCnt;
    logic [1:0]          offCnt;
    logic                offActive;
    logic                bodOffSleep;
    logic [13:0]         wakeCnt;
    logic [5:0]          stopMask;
    logic                adcWasOn;
    logic                extNext;
    logic                t0Undef;
    logic                adcStart;
    logic                awHave;
    logic [31:0]         awAddr;
    logic                wHave;
    logic [7:0]          wByte;
    logic                wLane;
    logic                bValid;
    logic [1:0]          bResp;
    logic                rValid;
    logic [31:0]         rData;
    logic [1:0]          rResp;
  } smg_state_s;

  smg_state_s q;
  smg_state_s d;

  logic inSleep;
  logic deepSleep;
  logic wakeEvent;
  logic pdWake;
  logic t0Wake;
  logic [13:0] startupCyc;
  logic [13:0] wakeLoad;
  logic cmpNeedsRef;

  // Start-up delay grows with the fuse code
  assign startupCyc = 14'((14'({10'h000, clockSelectFuse}) + 14'h0001) * smg_pkg::STARTUP_UNIT);

  assign inSleep   = (q.st == smg_pkg::ST_SLEEP) || (q.st == smg_pkg::ST_WAKE);
  assign deepSleep = inSleep && (q.mode == smg_pkg::SMG_PDOWN || q.mode == smg_pkg::SMG_PSAVE);

  // Wake filters per mode; level sources held by the far side
  assign pdWake = resetWake | wdtIrq | usiStart | extLevelIrq | pinChange;
  assign t0Wake = globalIrqEn & ((timer0Ovf & timer0IrqMask[0]) |
                                 (timer0Cmp & timer0IrqMask[1]));

  always_comb begin
    case (q.mode)
      smg_pkg::SMG_IDLE:  wakeEvent = irqAny | resetWake;
      smg_pkg::SMG_NOISE: wakeEvent = pdWake | adcDone | asyncTimerIrq | spmReady;
      smg_pkg::SMG_PDOWN: wakeEvent = pdWake;
      default:            wakeEvent = pdWake | t0Wake;
    endcase
  end

  // Deep modes use fuse start-up, monitor-off stretches further
  always_comb begin
    wakeLoad = (q.mode == smg_pkg::SMG_PDOWN || q.mode == smg_pkg::SMG_PSAVE) ?
               startupCyc : 14'h0001;
    if (q.bodOffSleep && wakeLoad < BOD_WAKE_CYCLES) begin
      wakeLoad = BOD_WAKE_CYCLES;
    end
  end

  // Next-state logic for the whole block
  always_comb begin
    d = q;
    d.adcStart = 1'b0;

    // Timed unlock window for the sleep-off bit
    if (q.unlockCnt != 3'h0) begin
      d.unlockCnt = q.unlockCnt - 3'h1;
    end
    if (q.armCnt != 2'h0) begin
      d.armCnt = q.armCnt - 2'h1;
      if (q.armCnt == 2'h1) begin
        d.offActive = 1'b1;
        d.offCnt    = smg_pkg::HOLD_CYC;
      end
    end else if (q.offCnt != 2'h0) begin
      d.offCnt = q.offCnt - 2'h1;
      if (q.offCnt == 2'h1) begin
        d.offActive = 1'b0;
      end
    end

    // Converter re-enable needs a long first conversion
    d.adcWasOn = adcEnabled;
    if (q.adcWasOn && !adcEnabled) begin
      d.extNext = 1'b1;
    end else if (adcEnabled && adcDone) begin
      d.extNext = 1'b0;
    end

    // Sleep sequencer
    case (q.st)
      smg_pkg::ST_RUN: begin
        if (sleepInstr && q.sleepAllow) begin
          d.st          = smg_pkg::ST_SLEEP;
          d.mode        = smg_pkg::smg_mode_e'(q.sleepSelect);
          d.bodOffSleep = q.offActive && q.sleepSelect[1];
          d.t0Undef     = 1'b0;
          d.adcStart    = adcEnabled && !q.sleepSelect[1];
        end
      end
      smg_pkg::ST_SLEEP: begin
        if (wakeEvent) begin
          d.st      = smg_pkg::ST_WAKE;
          d.wakeCnt = wakeLoad;
          d.t0Undef = (q.mode == smg_pkg::SMG_PSAVE) && !timer0AsyncSelect;
        end
      end
      smg_pkg::ST_WAKE: begin
        d.wakeCnt = q.wakeCnt - 14'h0001;
        if (q.wakeCnt <= 14'h0001) begin
          d.st          = smg_pkg::ST_HALT;
          d.wakeCnt     = smg_pkg::HALT_CYC;
          d.bodOffSleep = 1'b0;
        end
      end
      default: begin
        d.wakeCnt = q.wakeCnt - 14'h0001;
        if (q.wakeCnt == 14'h0001) begin
          d.st = smg_pkg::ST_RUN;
        end
      end
    endcase

    // Write channel capture, either order
    if (awvalid && awready) begin
      d.awHave = 1'b1;
      d.awAddr = awaddr;
    end
    if (wvalid && wready) begin
      d.wHave = 1'b1;
      d.wByte = wdata[7:0];
      d.wLane = wstrb[0];
    end

    // Register write once both halves are held
    if (q.awHave && q.wHave && !q.bValid) begin
      d.awHave = 1'b0;
      d.wHave  = 1'b0;
      d.bValid = 1'b1;
      d.bResp  = smg_pkg::RESP_OKAY;
      if (q.awAddr == smg_pkg::SLEEP_CTRL_ADDR) begin
        if (q.wLane) begin
          d.sleepAllow  = q.wByte[smg_pkg::ALLOW_BIT];
          d.sleepSelect = q.wByte[smg_pkg::SEL_LSB +: 2];
        end
      end else if (q.awAddr == smg_pkg::CORE_CTRL_ADDR) begin
        if (q.wLane && q.wByte[smg_pkg::OFF_BIT]) begin
          if (q.wByte[smg_pkg::UNLOCK_BIT]) begin
            if (q.unlockCnt == 3'h0) begin
              d.unlockCnt = smg_pkg::UNLOCK_CYC;
            end
          end else if (q.unlockCnt != 3'h0 && q.armCnt == 2'h0 && !q.offActive) begin
            d.armCnt    = smg_pkg::ARM_CYC;
            d.unlockCnt = 3'h0;
          end
        end
      end else if (q.awAddr == smg_pkg::STOP_MASK_ADDR) begin
        if (q.wLane) begin
          d.stopMask = q.wByte[5:0];
        end
      end else if (q.awAddr != smg_pkg::STATUS_ADDR) begin
        d.bResp = smg_pkg::RESP_SLVERR;
      end
    end
    if (q.bValid && bready) begin
      d.bValid = 1'b0;
    end

    // Read decode
    if (arvalid && arready) begin
      d.rValid = 1'b1;
      d.rResp  = smg_pkg::RESP_OKAY;
      d.rData  = 32'h0000_0000;
      if (araddr == smg_pkg::SLEEP_CTRL_ADDR) begin
        d.rData[smg_pkg::ALLOW_BIT]     = q.sleepAllow;
        d.rData[smg_pkg::SEL_LSB +: 2]  = q.sleepSelect;
      end else if (araddr == smg_pkg::CORE_CTRL_ADDR) begin
        d.rData[smg_pkg::OFF_BIT]    = q.offActive;
        d.rData[smg_pkg::UNLOCK_BIT] = (q.unlockCnt != 3'h0);
      end else if (araddr == smg_pkg::STOP_MASK_ADDR) begin
        d.rData[5:0] = q.stopMask;
      end else if (araddr == smg_pkg::STATUS_ADDR) begin
        d.rData[1:0] = q.st;
        d.rData[3:2] = q.mode;
        d.rData[4]   = q.bodOffSleep;
        d.rData[5]   = q.t0Undef;
        d.rData[6]   = q.extNext;
      end else begin
        d.rResp = smg_pkg::RESP_SLVERR;
      end
    end else if (q.rValid && rready) begin
      d.rValid = 1'b0;
    end
  end

  // State register; clock enable freezes everything
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      q             <= '0;
      q.st          <= smg_pkg::ST_RUN;
      q.mode        <= smg_pkg::SMG_IDLE;
      q.sleepSelect <= smg_pkg::SEL_RST;
      q.stopMask    <= smg_pkg::STOP_RST;
    end else if (clkEn) begin
      q <= d;
    end
  end

  // Bus handshakes held off while frozen so nothing is lost
  assign awready = clkEn && !q.awHave && !q.bValid;
  assign wready  = clkEn && !q.wHave && !q.bValid;
  assign arready = clkEn && !q.rValid;
  assign bvalid  = q.bValid;
  assign bresp   = q.bResp;
  assign rvalid  = q.rValid;
  assign rdata   = q.rData;
  assign rresp   = q.rResp;

  // Clock domain gating per mode
  assign cpuClkEn     = !inSleep;
  assign flashClkEn   = !inSleep;
  assign ioClkEn      = !(inSleep && q.mode != smg_pkg::SMG_IDLE);
  assign adcClkEn     = !deepSleep;
  assign mainOscEn    = !deepSleep;
  assign asyncClockEn = !(inSleep && q.mode == smg_pkg::SMG_PDOWN);
  assign coreHalt     = (q.st != smg_pkg::ST_RUN);

  // Per-peripheral stop; deeper modes already cut the I/O clock
  genvar gi;
  generate
    for (gi = 0; gi < smg_pkg::PERIPH_N; gi++) begin : g_periph
      assign periphClkEn[gi]    = ioClkEn && !q.stopMask[gi];
      assign periphAccessEn[gi] = !q.stopMask[gi];
    end
  endgenerate

  // Analog power; the monitor is only cut inside sleep proper
  assign brownoutMonitorOn  = brownoutThresholdFuse &&
                              !(q.st == smg_pkg::ST_SLEEP && q.bodOffSleep);
  assign cmpNeedsRef        = !comparatorOff && comparatorUsesRef;
  assign comparatorForceOff = deepSleep && !comparatorUsesRef;
  assign vrefOn             = brownoutMonitorOn || cmpNeedsRef || adcEnabled;
  assign adcAutoStart       = q.adcStart;
  assign adcExtendedNext    = q.extNext;
  assign timer0Undefined    = q.t0Undef;

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (sys_rst);

  chk_idle_clocks: assert property (q.st == smg_pkg::ST_SLEEP && q.mode == smg_pkg::SMG_IDLE
    |-> !cpuClkEn && ioClkEn && adcClkEn) else $error("idle clock set wrong");
  chk_noise_clocks: assert property (q.st == smg_pkg::ST_SLEEP && q.mode == smg_pkg::SMG_NOISE
    |-> !ioClkEn && adcClkEn && asyncClockEn) else $error("noise clock set wrong");
  chk_pdown_clocks: assert property (q.st == smg_pkg::ST_SLEEP && q.mode == smg_pkg::SMG_PDOWN
    |-> !mainOscEn && !asyncClockEn && !adcClkEn) else $error("power-down clocks on");
  chk_psave_async: assert property (q.st == smg_pkg::ST_SLEEP && q.mode == smg_pkg::SMG_PSAVE
    |-> asyncClockEn && !mainOscEn) else $error("power-save async clock wrong");
  chk_sleep_gate: assert property (clkEn && q.st == smg_pkg::ST_RUN && sleepInstr
    && !q.sleepAllow |=> q.st == smg_pkg::ST_RUN) else $error("sleep taken without allow");
  chk_off_expire: assert property (clkEn && q.offActive && q.offCnt == 2'h1 && q.armCnt == 2'h0
    |=> !q.offActive) else $error("sleep-off did not expire");
  chk_arm_delay: assert property (clkEn && q.armCnt == 2'h1 |=> q.offActive)
    else $error("sleep-off not active after arm");
  chk_monitor_back: assert property (q.st != smg_pkg::ST_SLEEP
    |-> brownoutMonitorOn == brownoutThresholdFuse) else $error("monitor not restored");
  chk_halt_len: assert property (clkEn && q.st == smg_pkg::ST_WAKE && q.wakeCnt <= 14'h0001
    ##1 clkEn [*4] |=> q.st == smg_pkg::ST_RUN) else $error("halt length wrong");
  chk_periph_stop: assert property (q.st == smg_pkg::ST_RUN && q.stopMask[0]
    |-> !periphClkEn[0] && !periphAccessEn[0]) else $error("stopped peripheral clocked");

endmodule
